//--- verilog/arsgc_defines.svh
// Offsets, field positions, reset values and widths of the result/sync/pin control block
// What this block does
// [RULE1] Short-word select picks 16 or 24-bit results
// [RULE2] Length change applies from next completed conversion; result read layout follows the new length at once
// [RULE3] Read-only 24-bit XOR checksum at 0x03
// [RULE4] Checksum reads zero while integrity check off
// [RULE5] Checked change sets error; disabling clears it
// [RULE6] Offset binary default, unipolar when selected
// [RULE7] Result read sets ready bit and pin high
// [RULE8] Result may be reread with identical data
// [RULE9] No result load while result read pending
// [RULE10] Status append makes result read 32 bits, or 24 bits with short word
// [RULE11] Mux drive puts channel on general pins
// [RULE12] At most four channels sequenced automatically
// [RULE13] Host should program settling delay for mux
// [RULE14] Sync enabled, alternate sync not in force: low pin holds filter reset
// [RULE15] Alternate sync needs more than one channel
// [RULE16] Alternate sync: low pin withholds next conversion
// [RULE17] Alternate sync: rising pin starts next conversion
// [RULE18] Host writes zero to reserved bits 15:13
// [RULE19] Checksum follows every checked register write
// [RULE20] Reserved pin configuration bits read zero
`ifndef ARSGC_DEFINES_SVH
`define ARSGC_DEFINES_SVH

`define ARSGC_ADDR_IF_MODE 6'h02
`define ARSGC_ADDR_CHECKSUM 6'h03
`define ARSGC_ADDR_RESULT 6'h04
`define ARSGC_ADDR_PIN_CFG 6'h06

`define ARSGC_CMD_READ_BIT 6
`define ARSGC_IF_SHORT_WORD_BIT 0
`define ARSGC_IF_INTEG_EN_BIT 5
`define ARSGC_IF_STAT_APPEND_BIT 6
`define ARSGC_IF_ALTERNATE_SYNC_MODE_BIT 12
`define ARSGC_IF_MODE_WMASK 16'h1061
`define ARSGC_IF_MODE_RESET 16'h0000

`define ARSGC_PIN_MUX_BIT 12
`define ARSGC_PIN_SYNC_EN_BIT 11
`define ARSGC_PIN_CFG_WMASK 16'h1FFF
`define ARSGC_PIN_CFG_RESET 16'h0800

`define ARSGC_CMD_BITS 6'd8
`define ARSGC_WRITE_BITS 6'd24

`endif

//--- verilog/arsgc_pkg.sv
// Types shared by the result/sync/pin control block
package arsgc_pkg;
    typedef enum logic [2:0] {
        LINK_CMD = 3'b001,
        LINK_WRITE = 3'b010,
        LINK_READ = 3'b100
    } arsgc_link_state_t;

    typedef logic [1:0] arsgc_chan_t;
endpackage : arsgc_pkg

//--- verilog/arsgc_ctrl.sv
// Result register, checksum, sync and external mux control with serial register port
`timescale 1ns/1ps
`include "arsgc_defines.svh"

module arsgc_ctrl #(
    parameter int CHANNELS = 4
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic CORE_CE,
    input wire logic SER_SCLK,
    input wire logic SER_CS_N,
    input wire logic SER_DIN,
    output logic SER_DOUT,
    output logic RDY_N,
    input wire logic CONV_DONE,
    input wire logic [23:0] CONV_CODE,
    input wire logic [CHANNELS-1:0] CHANNEL_ENABLE,
    input wire logic POLARITY_CODING_SELECT,
    input wire logic SYNC_N,
    output logic MOD_RESET,
    output logic CONV_HOLD,
    output arsgc_pkg::arsgc_chan_t CHANNEL_SEL,
    output logic REG_ERROR,
    output logic [1:0] GENERAL_PIN_OUT,
    output logic [1:0] GENERAL_PIN_OE
);
    import arsgc_pkg::*;

    // ---------------- Link domain (serial clock) ----------------
    arsgc_link_state_t link_state_r;
    arsgc_link_state_t link_state_nxt;
    logic [5:0] bit_cnt_r;
    logic [15:0] in_sh_r;
    logic [5:0] cmd_addr_r;
    logic [5:0] wr_addr_r;
    logic [15:0] wr_data_r;
    logic wr_tog_r;
    logic rd_tog_r;
    logic [31:0] out_sh_r;
    logic dout_r;
    wire frame_rst_n = RESET_N & ~SER_CS_N;
    wire cmd_last = (bit_cnt_r == `ARSGC_CMD_BITS - 6'd1);
    wire wr_last = (bit_cnt_r == `ARSGC_WRITE_BITS - 6'd1);
    wire cmd_is_read = in_sh_r[`ARSGC_CMD_READ_BIT - 1];
    wire first_rd_fall = (link_state_r == LINK_READ) && (bit_cnt_r == `ARSGC_CMD_BITS);
    logic [31:0] rd_hold_r;

    always_comb begin
        link_state_nxt = link_state_r;
        unique case (link_state_r)
            LINK_CMD: begin
                if (cmd_last) begin
                    link_state_nxt = cmd_is_read ? LINK_READ : LINK_WRITE;
                end
            end
            LINK_WRITE: begin
                if (wr_last) begin
                    link_state_nxt = LINK_CMD;
                end
            end
            LINK_READ: begin
                link_state_nxt = LINK_READ;
            end
            default: begin
                link_state_nxt = LINK_CMD;
            end
        endcase
    end

    // Frame counters end with chip select, not with a clock edge
    always_ff @(posedge SER_SCLK or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            link_state_r <= LINK_CMD;
            bit_cnt_r <= 6'd0;
            in_sh_r <= 16'h0000;
        end else begin
            link_state_r <= link_state_nxt;
            bit_cnt_r <= (bit_cnt_r == 6'h3F) ? bit_cnt_r : bit_cnt_r + 6'd1;
            in_sh_r <= {in_sh_r[14:0], SER_DIN};
        end
    end

    // Command and write words stay stable until the next frame's toggle
    always_ff @(posedge SER_SCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cmd_addr_r <= 6'd0;
            wr_addr_r <= 6'd0;
            wr_data_r <= 16'h0000;
            wr_tog_r <= 1'b0;
            rd_tog_r <= 1'b0;
        end else if (!SER_CS_N) begin
            if (link_state_r == LINK_CMD && cmd_last) begin
                cmd_addr_r <= {in_sh_r[4:0], SER_DIN};
                rd_tog_r <= rd_tog_r ^ cmd_is_read;
            end
            if (link_state_r == LINK_WRITE && wr_last) begin
                wr_addr_r <= cmd_addr_r;
                wr_data_r <= {in_sh_r[14:0], SER_DIN};
                wr_tog_r <= ~wr_tog_r;
            end
        end
    end

    // Hold word is loaded in the core a few cycles after the read toggle
    // and stays frozen until the next read, so it is stable on this edge
    always_ff @(negedge SER_SCLK or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            out_sh_r <= 32'h0000_0000;
            dout_r <= 1'b0;
        end else if (first_rd_fall) begin
            out_sh_r <= {rd_hold_r[30:0], 1'b0};
            dout_r <= rd_hold_r[31];
        end else begin
            out_sh_r <= {out_sh_r[30:0], 1'b0};
            dout_r <= out_sh_r[31];
        end
    end

    assign SER_DOUT = dout_r;

    // ---------------- Core domain ----------------
    logic [2:0] wr_sync_r;
    logic [2:0] rd_sync_r;
    logic [1:0] cs_sync_r;
    logic [1:0] sync_pin_r;
    logic sync_prev_r;
    logic [15:0] if_mode_r;
    logic [15:0] pin_cfg_r;
    logic [23:0] checksum_r;
    logic reg_err_r;
    logic [23:0] result_r;
    arsgc_chan_t result_ch_r;
    logic ready_n_r;
    logic reading_r;
    arsgc_chan_t chan_r;
    logic hold_r;
    logic [23:0] code_fmt;
    logic [7:0] status_byte;
    logic [7:0] status_sent;
    logic [31:0] result_word;
    logic [31:0] read_word;
    arsgc_chan_t chan_next;
    int unsigned en_count;

    wire wr_evt = wr_sync_r[2] ^ wr_sync_r[1];
    wire rd_evt = rd_sync_r[2] ^ rd_sync_r[1];
    wire frame_idle = cs_sync_r[1];
    wire sync_lvl = sync_pin_r[1];
    wire sync_rise = sync_lvl & ~sync_prev_r;
    wire short_word = if_mode_r[`ARSGC_IF_SHORT_WORD_BIT];
    wire integ_en = if_mode_r[`ARSGC_IF_INTEG_EN_BIT];
    wire stat_append = if_mode_r[`ARSGC_IF_STAT_APPEND_BIT];
    wire sync_en = pin_cfg_r[`ARSGC_PIN_SYNC_EN_BIT];
    wire mux_drive = pin_cfg_r[`ARSGC_PIN_MUX_BIT];
    wire alternate_sync_mode_mode = if_mode_r[`ARSGC_IF_ALTERNATE_SYNC_MODE_BIT] && (en_count > 1); // [RULE15]
    wire wr_if_mode = wr_evt && (wr_addr_r == `ARSGC_ADDR_IF_MODE);
    wire wr_pin_cfg = wr_evt && (wr_addr_r == `ARSGC_ADDR_PIN_CFG);
    wire [15:0] pin_cfg_new = wr_data_r & `ARSGC_PIN_CFG_WMASK; // [RULE20]
    wire [15:0] if_mode_new = wr_data_r & `ARSGC_IF_MODE_WMASK;
    wire integ_new = if_mode_new[`ARSGC_IF_INTEG_EN_BIT];
    wire checked_change = integ_en && wr_pin_cfg && (pin_cfg_new != pin_cfg_r);
    wire rd_result = rd_evt && (cmd_addr_r == `ARSGC_ADDR_RESULT);
    wire load_result = CONV_DONE && !reading_r && !rd_result; // [RULE9]
    wire switch_blocked = alternate_sync_mode_mode && sync_en && !sync_lvl;

    // Bipolar codes arrive two's complement; flipping the sign bit gives offset binary
    assign code_fmt = POLARITY_CODING_SELECT ? CONV_CODE
                    : {~CONV_CODE[23], CONV_CODE[22:0]}; // [RULE6]
    assign status_byte = {ready_n_r, 1'b0, reg_err_r, 3'b000, result_ch_r};
    assign status_sent = stat_append ? status_byte : 8'h00; // [RULE10]
    assign result_word = short_word ? {result_r[15:0], status_sent, 8'h00}
                       : {result_r, status_sent};

    always_comb begin
        en_count = 0;
        for (int i = 0; i < CHANNELS; i++) begin
            en_count = en_count + int'(CHANNEL_ENABLE[i]);
        end
    end

    // Sequencer walks at most four channels; mux codes follow it
    always_comb begin
        chan_next = chan_r;
        for (int i = CHANNELS - 1; i >= 1; i--) begin
            if (CHANNEL_ENABLE[(int'(chan_r) + i) % CHANNELS]) begin
                chan_next = arsgc_chan_t'((int'(chan_r) + i) % CHANNELS); // [RULE12]
            end
        end
    end

    always_comb begin
        read_word = 32'h0000_0000;
        unique case (cmd_addr_r)
            `ARSGC_ADDR_IF_MODE: read_word = {if_mode_r, 16'h0000};
            `ARSGC_ADDR_CHECKSUM: read_word = {checksum_r, 8'h00};
            `ARSGC_ADDR_RESULT: read_word = result_word; // [RULE8]
            `ARSGC_ADDR_PIN_CFG: read_word = {pin_cfg_r, 16'h0000};
            default: read_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_sync_r <= 3'b000;
            rd_sync_r <= 3'b000;
            cs_sync_r <= 2'b11;
            sync_pin_r <= 2'b11;
            sync_prev_r <= 1'b1;
        end else if (CORE_CE) begin
            wr_sync_r <= {wr_sync_r[1:0], wr_tog_r};
            rd_sync_r <= {rd_sync_r[1:0], rd_tog_r};
            cs_sync_r <= {cs_sync_r[0], SER_CS_N};
            sync_pin_r <= {sync_pin_r[0], SYNC_N};
            sync_prev_r <= sync_lvl;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            if_mode_r <= `ARSGC_IF_MODE_RESET;
            pin_cfg_r <= `ARSGC_PIN_CFG_RESET;
        end else if (CORE_CE) begin
            if (wr_if_mode) begin
                if_mode_r <= if_mode_new; // [RULE2]
            end
            if (wr_pin_cfg) begin
                pin_cfg_r <= pin_cfg_new;
            end
        end
    end

    // Checksum tracks the checked registers after every write
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            checksum_r <= 24'h00_0000;
            reg_err_r <= 1'b0;
        end else if (CORE_CE) begin
            checksum_r <= integ_en ? {8'h00, pin_cfg_r} : 24'h00_0000; // [RULE3] [RULE4] [RULE19]
            if (checked_change) begin
                reg_err_r <= 1'b1; // [RULE5]
            end else if (wr_if_mode && !integ_new) begin
                reg_err_r <= 1'b0; // [RULE5]
            end
        end
    end

    // Result capture; the length in force at completion is the one stored
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            result_r <= 24'h00_0000;
            result_ch_r <= 2'd0;
            ready_n_r <= 1'b1;
            reading_r <= 1'b0;
            rd_hold_r <= 32'h0000_0000;
        end else if (CORE_CE) begin
            if (load_result) begin
                result_r <= short_word ? {8'h00, code_fmt[23:8]} : code_fmt; // [RULE1] [RULE2]
                result_ch_r <= chan_r;
                ready_n_r <= 1'b0;
            end else if (rd_result) begin
                ready_n_r <= 1'b1; // [RULE7]
            end
            if (rd_result) begin
                reading_r <= 1'b1; // [RULE9]
            end else if (frame_idle) begin
                reading_r <= 1'b0;
            end
            if (rd_evt) begin
                rd_hold_r <= read_word; // [RULE10]
            end
        end
    end

    // Sync handling and channel stepping
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            chan_r <= 2'd0;
            hold_r <= 1'b0;
        end else if (CORE_CE) begin
            if (CONV_DONE) begin
                chan_r <= chan_next; // [RULE11]
            end
            if (CONV_DONE && switch_blocked) begin
                hold_r <= 1'b1; // [RULE16]
            end else if (sync_rise || !alternate_sync_mode_mode || !sync_en) begin
                hold_r <= 1'b0; // [RULE17]
            end
        end
    end

    assign MOD_RESET = sync_en && !alternate_sync_mode_mode && !sync_lvl; // [RULE14]
    assign CONV_HOLD = hold_r;
    assign CHANNEL_SEL = chan_r;
    assign RDY_N = ready_n_r; // [RULE7]
    assign REG_ERROR = reg_err_r;

    generate
        for (genvar p = 0; p < 2; p++) begin : g_pin
            assign GENERAL_PIN_OUT[p] = mux_drive & chan_r[p]; // [RULE11]
            assign GENERAL_PIN_OE[p] = mux_drive;
        end
    endgenerate
endmodule : arsgc_ctrl

//--- verif/arsgc_host_model.sv
// Host side model of the serial register link
`timescale 1ns/1ps
module arsgc_host_model (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout,
    output logic [31:0] rd_data,
    output logic rd_done
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
        rd_data = '0;
        rd_done = 1'b0;
    end

    // Clock stands high between frames; data after a frame is inverted
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int n);
        logic [31:0] sh;
        sh = '0;
        #7 cs_n = 1'b0;
        for (int i = 0; i < 8 + n; i++) begin
            #32 sclk = 1'b0;
            din = (i < 8) ? cmd[7-i] : (cmd[6] ? ~din : wd[23-i]);
            #32 sclk = 1'b1;
            if (i >= 8) sh = {sh[30:0], dout};
        end
        #32 cs_n = 1'b1;
        din = ~din;
        rd_data = sh;
        rd_done = cmd[6];
        #20 rd_done = 1'b0;
    endtask : xfer
endmodule : arsgc_host_model

//--- verif/arsgc_ctrl_monitor.sv
// Port-level assertions for the result, sync and pin control block
`timescale 1ns/1ps
module arsgc_ctrl_monitor #(
    parameter int CHANNELS = 4
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic CORE_CE,
    input wire logic SER_CS_N,
    input wire logic RDY_N,
    input wire logic CONV_DONE,
    input wire logic [CHANNELS-1:0] CHANNEL_ENABLE,
    input wire logic SYNC_N,
    input wire logic MOD_RESET,
    input wire logic CONV_HOLD,
    input wire arsgc_pkg::arsgc_chan_t CHANNEL_SEL,
    input wire logic [1:0] GENERAL_PIN_OUT,
    input wire logic [1:0] GENERAL_PIN_OE
);
    import arsgc_pkg::*;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_conv;
        CONV_DONE && CORE_CE;
    endsequence
    sequence s_hold_rise;
        CONV_HOLD && !$past(SYNC_N) && SYNC_N;
    endsequence

    a_mux_address: assert property (GENERAL_PIN_OE[0] |-> GENERAL_PIN_OUT == CHANNEL_SEL)
        else $error("mux pins differ from channel");
    a_pin_idle: assert property (GENERAL_PIN_OE[0] == GENERAL_PIN_OE[1] &&
        (GENERAL_PIN_OE[0] || GENERAL_PIN_OUT == 2'b00)) else $error("pin drive mismatch");
    a_load_ready: assert property (s_conv and SER_CS_N |=> !RDY_N)
        else $error("result load left ready high");
    a_ready_fall: assert property ($fell(RDY_N) |-> $past(CONV_DONE))
        else $error("ready without conversion");
    a_sync_reset: assert property (MOD_RESET |->
        !$past(SYNC_N, 1) || !$past(SYNC_N, 2) || !$past(SYNC_N, 3))
        else $error("filter reset without low sync");
    a_chan_enabled: assert property (s_conv and |CHANNEL_ENABLE |=>
        CHANNEL_ENABLE[CHANNEL_SEL]) else $error("disabled channel selected");
    a_chan_steady: assert property (!CONV_DONE |=> $stable(CHANNEL_SEL))
        else $error("channel moved without conversion");
    a_hold_cause: assert property ($rose(CONV_HOLD) |->
        $past(CONV_DONE) && $countones($past(CHANNEL_ENABLE)) > 1)
        else $error("hold without multi-channel conversion");
    a_hold_release: assert property (s_hold_rise |-> ##[1:5] !CONV_HOLD)
        else $error("hold not released by sync rise");
endmodule : arsgc_ctrl_monitor

bind arsgc_ctrl arsgc_ctrl_monitor #(.CHANNELS(CHANNELS)) i_monitor (.CORE_CLK, .RESET_N,
    .CORE_CE, .SER_CS_N, .RDY_N, .CONV_DONE, .CHANNEL_ENABLE, .SYNC_N, .MOD_RESET,
    .CONV_HOLD, .CHANNEL_SEL, .GENERAL_PIN_OUT, .GENERAL_PIN_OE);

//--- verif/testbench.sv
// Self-checking bench for the result, checksum, sync and pin control block
`timescale 1ns/1ps
module testbench;
    import arsgc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic done = 1'b0;
    logic pol = 1'b0;
    logic sync_n = 1'b1;
    logic [23:0] code = '0;
    logic [3:0] en = 4'h1;
    logic sclk, cs_n, din, dout, rdy_n, mod_rst, hold, err, rd_done;
    arsgc_chan_t chan;
    logic [1:0] gp_out, gp_oe;
    logic [31:0] rd_data, m, e;
    logic [63:0] expq[$];
    logic [15:0] pin;
    logic [23:0] c;
    int checked = 0;
    int miscompares = 0;

    always #2.5 clk = ~clk;

    arsgc_ctrl #(.CHANNELS(4)) i_dut (.CORE_CLK(clk), .RESET_N(rst_n), .CORE_CE(ce),
        .SER_SCLK(sclk), .SER_CS_N(cs_n), .SER_DIN(din), .SER_DOUT(dout), .RDY_N(rdy_n),
        .CONV_DONE(done), .CONV_CODE(code), .CHANNEL_ENABLE(en),
        .POLARITY_CODING_SELECT(pol), .SYNC_N(sync_n), .MOD_RESET(mod_rst),
        .CONV_HOLD(hold), .CHANNEL_SEL(chan), .REG_ERROR(err), .GENERAL_PIN_OUT(gp_out),
        .GENERAL_PIN_OE(gp_oe));
    arsgc_host_model i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .rd_data(rd_data), .rd_done(rd_done));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic flag(input logic got, input logic exp);
        #1;
        chk({31'h0, got}, {31'h0, exp});
        @(posedge clk);
    endtask : flag
    task automatic rd(input logic [5:0] a, input int n, input logic [31:0] x,
            input logic [31:0] k);
        expq.push_back({k, x});
        i_host.xfer({2'b01, a}, 16'h0000, n);
        cyc(8);
    endtask : rd
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        i_host.xfer({2'b00, a}, d, 16);
        cyc(8);
    endtask : wr
    task automatic conv(input logic [23:0] v);
        @(posedge clk);
        done <= 1'b1;
        code <= v;
        @(posedge clk);
        done <= 1'b0;
    endtask : conv
    task automatic tally_and_finish;
        // A read whose answer never arrived is a mismatch too
        if (expq.size() != 0) begin
            miscompares++;
        end
        $display("Checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // Each completed read takes the oldest expectation
    initial forever begin
        @(posedge rd_done);
        {m, e} = expq.pop_front();
        chk(rd_data & m, e & m);
    end

    initial begin
        #400000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(57));
        cyc(3);
        rst_n <= 1'b1;
        cyc(3);
        rd(6'h06, 16, 32'h0000_0800, '1);
        rd(6'h03, 24, 32'h0, '1);
        rd(6'h04, 24, 32'h0, '1);
        rd(6'h02, 16, 32'h0, '1);
        rd(6'h05, 16, 32'h0, '1);
        // Reserved ones on purpose: they must read back as zero
        pin = {5'b11111, 11'($urandom())};
        wr(6'h06, pin);
        rd(6'h06, 16, {19'h0, pin[12:0]}, '1);
        flag(gp_oe[0], 1'b1);
        rd(6'h03, 24, 32'h0, '1);
        wr(6'h02, 16'h0020);
        rd(6'h03, 24, {19'h0, pin[12:0]}, '1);
        flag(err, 1'b0);
        pin = {3'b000, pin[12:0] ^ 13'h0001};
        wr(6'h06, pin);
        flag(err, 1'b1);
        rd(6'h03, 24, {16'h0, pin}, '1);
        wr(6'h02, 16'h0000);
        flag(err, 1'b0);
        rd(6'h03, 24, 32'h0, '1);
        for (int p = 0; p < 2; p++) begin
            c = 24'($urandom());
            pol <= p[0];
            conv(c);
            cyc(2);
            flag(rdy_n, 1'b0);
            rd(6'h04, 24, {8'h0, p[0] ? c : c ^ 24'h80_0000}, '1);
            flag(rdy_n, 1'b1);
            rd(6'h04, 24, {8'h0, p[0] ? c : c ^ 24'h80_0000}, '1);
        end
        c = 24'($urandom());
        conv(c);
        fork
            rd(6'h04, 24, {8'h0, c}, '1);
            begin
                #1200;
                conv(~c);
            end
        join
        flag(rdy_n, 1'b1);
        rd(6'h04, 24, {8'h0, c}, '1);
        wr(6'h02, 16'h0041);
        c = 24'($urandom());
        conv(c);
        rd(6'h04, 24, {8'h0, c[23:8], 8'h00}, '1);
        rd(6'h04, 24, {8'h0, c[23:8], 8'h80}, '1);
        wr(6'h02, 16'h0040);
        c = 24'($urandom());
        conv(c);
        rd(6'h04, 32, {c, 8'h00}, '1);
        wr(6'h02, 16'h0000);
        sync_n <= 1'b0;
        cyc(5);
        flag(mod_rst, 1'b1);
        sync_n <= 1'b1;
        cyc(5);
        flag(mod_rst, 1'b0);
        wr(6'h02, 16'h1000);
        en <= 4'h3;
        sync_n <= 1'b0;
        cyc(5);
        flag(mod_rst, 1'b0);
        conv(24'($urandom()));
        cyc(2);
        flag(hold, 1'b1);
        flag(gp_out[0], 1'b1);
        flag(gp_out[1], 1'b0);
        sync_n <= 1'b1;
        cyc(6);
        flag(hold, 1'b0);
        en <= 4'h1;
        sync_n <= 1'b0;
        cyc(5);
        flag(mod_rst, 1'b1);
        sync_n <= 1'b1;
        // Let the high sync level through the synchroniser before the enable toggles
        cyc(4);
        repeat (20) begin
            en <= 4'($urandom_range(15, 1));
            ce <= 1'($urandom());
            conv(24'($urandom()));
            cyc(4);
        end
        ce <= 1'b1;
        cyc(4);
        tally_and_finish();
    end
endmodule : testbench
